// ### rtl/rfc_regs.sv
// fault handling control and first fault status registers
`timescale 1ns/1ps
module rfc_regs
	import rfc_pkg::*;
#(
	parameter logic [rfc_pkg::KEY_W-1:0] UNLOCK_KEY_ONE_VALUE =
		rfc_pkg::KEY1_DEFAULT,
	parameter logic [rfc_pkg::KEY_W-1:0] UNLOCK_KEY_TWO_VALUE =
		rfc_pkg::KEY2_DEFAULT
)
(
	// clock, reset, enable
	input  wire logic                        clk_i,
	input  wire logic                        nrst_i,
	input  wire logic                        ce_i,
	// local memory bus slave
	input  wire logic [rfc_pkg::ADDR_W-1:0]  bus_addr_i,
	input  wire logic                        bus_as_i,
	input  wire logic                        bus_rd_i,
	input  wire logic                        bus_wr_i,
	input  wire logic [3:0]                  bus_be_i,
	input  wire logic [rfc_pkg::DATA_W-1:0]  bus_wdata_i,
	output logic [rfc_pkg::DATA_W-1:0]       bus_rdata_o,
	output logic                             bus_ready_o,
	// fault events from the manager
	input  wire logic                        watchdog_expired_i,
	input  wire logic                        fatal_uncorrectable_i,
	input  wire logic                        fatal_voter_i,
	input  wire logic [2:0]                  fatal_pair_i,
	input  wire logic                        restore_done_i,
	input  wire logic [2:0]                  lockstep_mismatch_i,
	input  wire logic                        fatal_state_i,
	input  wire logic                        recover_req_i,
	// fault handling outputs
	output logic                             fatal_o,
	output logic                             break_o,
	output logic                             sys_reset_o,
	output logic                             recoverable_o,
	output logic                             key_two_ok_o
);
	// shared address compare
	function automatic logic hit(input logic [ADDR_W-1:0] a,
		input logic [ADDR_W-1:0] off);
		hit = (a == off);
	endfunction : hit

	logic [KEY_W-1:0]  unlock_key_one;
	logic [KEY_W-1:0]  unlock_key_two;
	logic              fatal_output_block_bit;
	logic              break_block_bit;
	logic              fatal_reset_block_bit;
	logic              recover_as_reset_bit;
	logic              key_one_ok;
	logic              key_two_ok;
	logic [FLAG_W-1:0] first_fault_status;
	logic [FLAG_W-1:0] flag_set;
	logic              flag_clr;
	logic              take_rd;
	logic              take_wr;
	logic              wr_ctrl;
	logic              wr_ffs;
	logic              rd_ffs;
	logic [DATA_W-1:0] next_rdata;
	logic [1:0]        mism_count;
	logic              next_fatal;
	logic              next_break;
	logic              next_reset;

	// key compares against build values
	rfc_key_match #(
		.VALUE (UNLOCK_KEY_ONE_VALUE)
	) u_key_one (
		.key_i   (unlock_key_one),
		.match_o (key_one_ok)
	);

	rfc_key_match #(
		.VALUE (UNLOCK_KEY_TWO_VALUE)
	) u_key_two (
		.key_i   (unlock_key_two),
		.match_o (key_two_ok)
	);

	assign take_rd = ce_i & bus_as_i & bus_rd_i;
	assign take_wr = ce_i & bus_as_i & bus_wr_i;
	assign wr_ctrl = take_wr & hit(bus_addr_i, OFF_CTRL);
	assign wr_ffs  = take_wr & hit(bus_addr_i, OFF_FFS);
	assign rd_ffs  = take_rd & hit(bus_addr_i, OFF_FFS);

	// read data select
	// control and unmapped offsets read zero, so no data leaks
	assign next_rdata = rd_ffs ? {{(DATA_W-FLAG_W){1'b0}},
		first_fault_status} : RDATA_RST;

	// bus answer one cycle after the strobe
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			bus_ready_o <= 1'b0;
			bus_rdata_o <= RDATA_RST;
		end
		else if (ce_i)
		begin
			bus_ready_o <= take_rd | take_wr;
			bus_rdata_o <= next_rdata;
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			unlock_key_two <= CTRL_RST[CTRL_KEY2_LSB +: KEY_W];
		else if (wr_ctrl && bus_be_i[1])
			unlock_key_two <= bus_wdata_i[CTRL_KEY2_LSB +: KEY_W];
	end

	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			unlock_key_one <= CTRL_RST[CTRL_KEY1_LSB +: KEY_W];
		else if (wr_ctrl && bus_be_i[0])
			unlock_key_one <= bus_wdata_i[CTRL_KEY1_LSB +: KEY_W];
	end

	// option bits, bits 31-20 are never stored
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			fatal_output_block_bit <= CTRL_RST[CTRL_FATAL_OUT_BLK];
			break_block_bit        <= CTRL_RST[CTRL_BREAK_BLK];
			fatal_reset_block_bit  <= CTRL_RST[CTRL_FATAL_RST_BLK];
			recover_as_reset_bit   <= CTRL_RST[CTRL_RECOVER_RST];
		end
		else if (wr_ctrl && bus_be_i[2])
		begin
			fatal_output_block_bit <= bus_wdata_i[CTRL_FATAL_OUT_BLK];
			break_block_bit        <= bus_wdata_i[CTRL_BREAK_BLK];
			fatal_reset_block_bit  <= bus_wdata_i[CTRL_FATAL_RST_BLK];
			recover_as_reset_bit   <= bus_wdata_i[CTRL_RECOVER_RST];
		end
	end

	// event placement, reserved bits never set
	always_comb
	begin
		flag_set = FFS_RST;
		flag_set[FFS_WATCHDOG]             = watchdog_expired_i;
		flag_set[FFS_FATAL_UE]             = fatal_uncorrectable_i;
		flag_set[FFS_FATAL_VOTE]           = fatal_voter_i;
		flag_set[FFS_FATAL_LSB +: 3]       = fatal_pair_i;
		flag_set[FFS_RESTORE]              = restore_done_i;
		flag_set[FFS_MISM_LSB +: 3]        = lockstep_mismatch_i;
	end

	assign flag_clr = wr_ffs & key_one_ok;

	rfc_sticky_bank u_flags (
		.clk_i  (clk_i),
		.nrst_i (nrst_i),
		.ce_i   (ce_i),
		.set_i  (flag_set),
		.clr_i  (flag_clr),
		.q_o    (first_fault_status)
	);

	assign next_fatal = fatal_state_i &
		~(fatal_output_block_bit & key_two_ok);
	assign next_break = fatal_state_i & ~(break_block_bit & key_one_ok);
	assign next_reset = (fatal_state_i &
		~(fatal_reset_block_bit & key_two_ok)) |
		(recover_req_i & recover_as_reset_bit & key_one_ok);

	// recoverable only when exactly two pairs disagree
	assign mism_count = 2'(first_fault_status[0]) +
		2'(first_fault_status[1]) + 2'(first_fault_status[2]);

	// handling outputs registered for clean pins
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			fatal_o       <= 1'b0;
			break_o       <= 1'b0;
			sys_reset_o   <= 1'b0;
			recoverable_o <= 1'b0;
			key_two_ok_o  <= 1'b0;
		end
		else if (ce_i)
		begin
			fatal_o       <= next_fatal;
			break_o       <= next_break;
			sys_reset_o   <= next_reset;
			recoverable_o <= (mism_count == 2'd2);
			key_two_ok_o  <= key_two_ok;
		end
	end

	// checks on the bank
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!nrst_i);

	logic rd_ctrl_q;
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			rd_ctrl_q <= 1'b0;
		else if (ce_i)
			rd_ctrl_q <= take_rd & hit(bus_addr_i, OFF_CTRL);
	end

	property p_ctrl_reads_zero;
		rd_ctrl_q |-> bus_ready_o && bus_rdata_o == 32'h0000_0000;
	endproperty
	a_ctrl_reads_zero: assert property (p_ctrl_reads_zero)
		else $error("control read not zero or not acknowledged");

	property p_fatal_block;
		ce_i && fatal_state_i && fatal_output_block_bit && key_two_ok
			|=> !fatal_o;
	endproperty
	a_fatal_block: assert property (p_fatal_block)
		else $error("fatal output not blocked");

	property p_fatal_pass;
		ce_i && fatal_state_i && !key_two_ok |=> fatal_o && sys_reset_o;
	endproperty
	a_fatal_pass: assert property (p_fatal_pass)
		else $error("locked key two still blocks fatal");

	property p_break;
		ce_i && fatal_state_i |=>
			break_o == !($past(break_block_bit) && $past(key_one_ok));
	endproperty
	a_break: assert property (p_break)
		else $error("break gating wrong");

	property p_fatal_reset_block;
		ce_i && fatal_state_i && !recover_req_i &&
			fatal_reset_block_bit && key_two_ok |=> !sys_reset_o;
	endproperty
	a_fatal_reset_block: assert property (p_fatal_reset_block)
		else $error("fatal reset not blocked");

	property p_recover_reset;
		ce_i && recover_req_i |=> sys_reset_o ||
			!($past(recover_as_reset_bit) && $past(key_one_ok));
	endproperty
	a_recover_reset: assert property (p_recover_reset)
		else $error("recover did not reset");

	property p_clear;
		flag_clr && flag_set == 22'h00_0000 |=>
			first_fault_status == 22'h00_0000;
	endproperty
	a_clear: assert property (p_clear)
		else $error("unlocked write did not clear status");

	property p_locked_keep;
		wr_ffs && !key_one_ok |=>
			(first_fault_status & $past(first_fault_status)) ==
			$past(first_fault_status);
	endproperty
	a_locked_keep: assert property (p_locked_keep)
		else $error("locked write cleared status");

	property p_events;
		ce_i && watchdog_expired_i && lockstep_mismatch_i[1] |=>
			first_fault_status[21] && first_fault_status[1];
	endproperty
	a_events: assert property (p_events)
		else $error("event flag not captured");

	property p_sticky;
		ce_i && !flag_clr && first_fault_status[19] ##1 !flag_clr [*2]
			|-> first_fault_status[19];
	endproperty
	a_sticky: assert property (p_sticky)
		else $error("status flag dropped without clear");

	property p_reserved;
		rd_ffs |=> bus_rdata_o[31:22] == 10'h000 &&
			bus_rdata_o[15:4] == 12'h000;
	endproperty
	a_reserved: assert property (p_reserved)
		else $error("reserved status bits not zero");

	property p_recoverable;
		ce_i |=> recoverable_o ==
			($countones($past(first_fault_status[2:0])) == 2);
	endproperty
	a_recoverable: assert property (p_recoverable)
		else $error("recoverable flag wrong");

	// one answer per strobe
	// a late or doubled answer would let the master take stale data
	property p_ready_once;
		ce_i |=> bus_ready_o == $past(take_rd | take_wr);
	endproperty
	a_ready_once: assert property (p_ready_once)
		else $error("bus answer not one cycle after strobe");

	// status read returns the stored flags
	property p_status_read;
		rd_ffs |=> bus_rdata_o[21:0] == $past(first_fault_status);
	endproperty
	a_status_read: assert property (p_status_read)
		else $error("status read data wrong");

	// enable low holds flags, keys and outputs
	property p_freeze;
		!ce_i |=> $stable(first_fault_status) && $stable(fatal_o) &&
			$stable(unlock_key_one);
	endproperty
	a_freeze: assert property (p_freeze)
		else $error("state moved while enable low");

	c_clear: cover property (flag_clr ##1 first_fault_status == '0);
	c_ctrl_write: cover property (wr_ctrl ##1 key_one_ok && key_two_ok);
	c_two_mism: cover property (recoverable_o);
	c_blocked_fatal: cover property (fatal_state_i && !fatal_o);
endmodule : rfc_regs

// ### rtl/rfc_pkg.sv
// constants shared by the redundancy fault control register bank
package rfc_pkg;
	// bus geometry
	localparam int unsigned ADDR_W = 32;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned KEY_W  = 8;
	localparam int unsigned FLAG_W = 22;
	localparam int unsigned CTRL_W = 20;

	// register offsets
	localparam logic [ADDR_W-1:0] OFF_CTRL = 32'h0000_0000;
	localparam logic [ADDR_W-1:0] OFF_FFS  = 32'h0000_0004;

	// control field positions
	localparam int unsigned CTRL_FATAL_OUT_BLK = 19;
	localparam int unsigned CTRL_BREAK_BLK     = 18;
	localparam int unsigned CTRL_FATAL_RST_BLK = 17;
	localparam int unsigned CTRL_RECOVER_RST   = 16;
	localparam int unsigned CTRL_KEY2_LSB      = 8;
	localparam int unsigned CTRL_KEY1_LSB      = 0;

	// first fault status field positions
	localparam int unsigned FFS_WATCHDOG   = 21;
	localparam int unsigned FFS_FATAL_UE   = 20;
	localparam int unsigned FFS_FATAL_VOTE = 19;
	localparam int unsigned FFS_FATAL_LSB  = 16;
	localparam int unsigned FFS_RESTORE    = 3;
	localparam int unsigned FFS_MISM_LSB   = 0;

	// values after reset
	localparam logic [CTRL_W-1:0] CTRL_RST  = 20'h0_0000;
	localparam logic [FLAG_W-1:0] FFS_RST   = 22'h00_0000;
	localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;

	// unlock key defaults, values are arbitrary build choices
	localparam logic [KEY_W-1:0] KEY1_DEFAULT = 8'h5A;
	localparam logic [KEY_W-1:0] KEY2_DEFAULT = 8'hA5;

	// bus answer latency in cycles
	localparam int unsigned ACK_CYCLES = 1;
endpackage : rfc_pkg

// ### rtl/rfc_key_match.sv
// compares a stored unlock key with its build value
`timescale 1ns/1ps
module rfc_key_match
	import rfc_pkg::*;
#(
	parameter logic [rfc_pkg::KEY_W-1:0] VALUE = rfc_pkg::KEY1_DEFAULT
)
(
	// key input
	input  wire logic [rfc_pkg::KEY_W-1:0] key_i,
	// match result
	output logic                           match_o
);
	// pure compare, the stored key is already a flip-flop
	assign match_o = (key_i == VALUE);
endmodule : rfc_key_match

// ### rtl/rfc_sticky_bank.sv
// bank of sticky flags, set wins over clear
`timescale 1ns/1ps
module rfc_sticky_bank
	import rfc_pkg::*;
(
	// clock, reset, enable
	input  wire logic                    clk_i,
	input  wire logic                    nrst_i,
	input  wire logic                    ce_i,
	// set and clear
	input  wire logic [rfc_pkg::FLAG_W-1:0] set_i,
	input  wire logic                    clr_i,
	// flag state
	output logic [rfc_pkg::FLAG_W-1:0]   q_o
);
	genvar g;

	// one flop per flag; an event in the clear cycle is kept
	generate
		for (g = 0; g < FLAG_W; g++)
		begin : g_flag
			always_ff @(posedge clk_i or negedge nrst_i)
			begin
				if (!nrst_i)
					q_o[g] <= FFS_RST[g];
				else if (ce_i)
					q_o[g] <= set_i[g] | (q_o[g] & ~clr_i);
			end
		end
	endgenerate
endmodule : rfc_sticky_bank

// ### verif/rfc_cpu_model.sv
// processor-side bus master model for the fault control registers
`timescale 1ns/1ps
module rfc_cpu_model
	import rfc_pkg::*;
(
	// clock
	input  wire logic                       clk_i,
	// bus request
	output logic [rfc_pkg::ADDR_W-1:0]      bus_addr_o,
	output logic                            bus_as_o,
	output logic                            bus_rd_o,
	output logic                            bus_wr_o,
	output logic [3:0]                      bus_be_o,
	output logic [rfc_pkg::DATA_W-1:0]      bus_wdata_o,
	// bus answer
	input  wire logic [rfc_pkg::DATA_W-1:0] bus_rdata_i,
	input  wire logic                       bus_ready_i
);
	// idle bus at time zero
	initial
	begin
		bus_addr_o  = '0;
		bus_as_o    = 1'b0;
		bus_rd_o    = 1'b0;
		bus_wr_o    = 1'b0;
		bus_be_o    = 4'hF;
		bus_wdata_o = '0;
	end

	// one word transfer; strobe is a one-cycle pulse, answer one cycle on
	task automatic xfer(input logic wr, input logic [ADDR_W-1:0] addr,
		input logic [DATA_W-1:0] data, output logic [DATA_W-1:0] rdata,
		output logic ok);
		@(negedge clk_i);
		bus_addr_o  = addr;
		bus_wdata_o = data;
		bus_as_o    = 1'b1;
		bus_rd_o    = ~wr;
		bus_wr_o    = wr;
		@(negedge clk_i);
		ok          = bus_ready_i;
		rdata       = bus_rdata_i;
		bus_as_o    = 1'b0;
		bus_rd_o    = 1'b0;
		bus_wr_o    = 1'b0;
		// released lines flip so stale values never look valid
		bus_addr_o  = ~addr;
		bus_wdata_o = ~data;
	endtask : xfer

	// byte lanes for the following transfers
	task automatic set_be(input logic [3:0] be);
		bus_be_o = be;
	endtask : set_be
endmodule : rfc_cpu_model

// ### verif/tb_top.sv
// self-checking bench for the fault control register bank
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; \
	$display("[ERR] %0t value mismatch", $time); end end
module tb_top;
	import rfc_pkg::*;
	logic              clk_i  = 1'b0;
	logic              nrst_i = 1'b0;
	logic              ce_i   = 1'b1;
	logic [ADDR_W-1:0] addr;
	logic              as_s, rd_s, wr_s, ready;
	logic [3:0]        be;
	logic [DATA_W-1:0] wdata, rdata, got;
	logic              wd = 1'b0, ue = 1'b0, vote = 1'b0, rest = 1'b0;
	logic [2:0]        pair = 3'h0, mism = 3'h0;
	logic              fst = 1'b0, restore_done_flag = 1'b0;
	logic              fatal, brk, srst, recov, k2ok;
	int                err_count = 0, tests_run = 0, cycles = 0;
	// event rows: {wd,ue,vote,pair,restore,mism}, status, recoverable
	localparam logic [9:0] EV [12] = '{10'h200, 10'h100, 10'h080, 10'h040,
		10'h020, 10'h010, 10'h008, 10'h003, 10'h006, 10'h005, 10'h001,
		10'h007};
	localparam logic [31:0] ST [12] = '{32'h0020_0000, 32'h0010_0000,
		32'h0008_0000, 32'h0004_0000, 32'h0002_0000, 32'h0001_0000,
		32'h0000_0008, 32'h0000_0003, 32'h0000_0006, 32'h0000_0005,
		32'h0000_0001, 32'h0000_0007};
	localparam logic [11:0] RC = 12'b000000011100;
	// option rows: {opt[19:16], key2 ok, key1 ok, fatal state, recover}
	localparam logic [7:0] OI [6] = '{8'hFF, 8'hF3, 8'h0E, 8'h15, 8'h11,
		8'hAE};
	// expected {fatal, break, reset, key two ok}
	localparam logic [3:0] OE [6] = '{4'b0011, 4'b1110, 4'b1111, 4'b0010,
		4'b0000, 4'b0101};
	localparam logic [31:0] UNLOCK = {16'h0000, KEY2_DEFAULT, KEY1_DEFAULT};

	// 10 MHz clock
	always #50 clk_i = ~clk_i;

	rfc_regs dut_u (.clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce_i),
		.bus_addr_i(addr), .bus_as_i(as_s), .bus_rd_i(rd_s),
		.bus_wr_i(wr_s), .bus_be_i(be), .bus_wdata_i(wdata),
		.bus_rdata_o(rdata), .bus_ready_o(ready),
		.watchdog_expired_i(wd), .fatal_uncorrectable_i(ue),
		.fatal_voter_i(vote), .fatal_pair_i(pair), .restore_done_i(rest),
		.lockstep_mismatch_i(mism), .fatal_state_i(fst),
		.recover_req_i(restore_done_flag), .fatal_o(fatal), .break_o(brk),
		.sys_reset_o(srst), .recoverable_o(recov), .key_two_ok_o(k2ok));

	rfc_cpu_model cpu_u (.clk_i(clk_i), .bus_addr_o(addr), .bus_as_o(as_s),
		.bus_rd_o(rd_s), .bus_wr_o(wr_s), .bus_be_o(be),
		.bus_wdata_o(wdata), .bus_rdata_i(rdata), .bus_ready_i(ready));

	task automatic results();
		$display("tests_run %0d err_count %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : results

	task automatic bw(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        k;
		cpu_u.xfer(1'b1, a, d, r, k);
		`CHK(k, 1'b1)
	endtask : bw

	task automatic br(input logic [31:0] a, output logic [31:0] d);
		logic k;
		cpu_u.xfer(1'b0, a, 32'h0000_0000, d, k);
		`CHK(k, 1'b1)
	endtask : br

	// one-cycle pulse on the event inputs
	task automatic pulse(input logic [9:0] ev);
		@(negedge clk_i);
		{wd, ue, vote, pair, rest, mism} = ev;
		@(negedge clk_i);
		{wd, ue, vote, pair, rest, mism} = 10'h000;
	endtask : pulse

	// hang guard, the run needs well under a thousand cycles
	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles >= 4000)
		begin
			err_count++;
			results();
		end
	end

	initial
	begin
		repeat (10) @(negedge clk_i);
		nrst_i = 1'b1;
		@(negedge clk_i);
		`CHK({fatal, brk, srst, recov, k2ok}, 5'b00000)
		br(OFF_FFS, got);
		`CHK(got, 32'h0000_0000)
		bw(OFF_CTRL, UNLOCK);
		br(OFF_CTRL, got);
		`CHK(got, 32'h0000_0000)
		br(32'h0000_0008, got);
		`CHK(got, 32'h0000_0000)
		// every event and mismatch patterns 1, 3, 5, 6 and 7, cleared between rows
		for (int i = 0; i < 12; i++)
		begin
			bw(OFF_CTRL, UNLOCK);
			bw(OFF_FFS, 32'hFFFF_FFFF);
			br(OFF_FFS, got);
			`CHK(got, 32'h0000_0000)
			pulse(EV[i]);
			br(OFF_FFS, got);
			`CHK(got, ST[i])
			`CHK(recov, RC[11-i])
		end
		// option bits against key gating
		for (int i = 0; i < 6; i++)
		begin
			@(negedge clk_i);
			fst = OI[i][1];
			restore_done_flag = OI[i][0];
			bw(OFF_CTRL, {12'h000, OI[i][7:4], OI[i][3] ? KEY2_DEFAULT :
				8'h00, OI[i][2] ? KEY1_DEFAULT : 8'h00});
			repeat (2) @(negedge clk_i);
			`CHK({fatal, brk, srst, k2ok}, OE[i])
		end
		fst = 1'b0;
		restore_done_flag = 1'b0;
		// locked clear leaves flags standing
		bw(OFF_CTRL, UNLOCK);
		bw(OFF_FFS, 32'h0000_0000);
		pulse(10'h200);
		bw(OFF_CTRL, {UNLOCK[31:8], 8'h00});
		bw(OFF_FFS, 32'hFFFF_FFFF);
		repeat (3) @(negedge clk_i);
		br(OFF_FFS, got);
		`CHK(got, 32'h0020_0000)
		// reserved control bits are not options
		bw(OFF_CTRL, {12'hFFF, 4'h0, UNLOCK[15:0]});
		fst = 1'b1;
		repeat (2) @(negedge clk_i);
		`CHK({fatal, brk, srst}, 3'b111)
		fst = 1'b0;
		// enable low freezes flags and outputs
		@(negedge clk_i);
		ce_i = 1'b0;
		fst  = 1'b1;
		pulse(10'h008);
		`CHK({fatal, brk, srst}, 3'b000)
		ce_i = 1'b1;
		fst  = 1'b0;
		br(OFF_FFS, got);
		`CHK(got, 32'h0020_0000)
		// option lane disabled leaves the option bits clear
		cpu_u.set_be(4'h3);
		bw(OFF_CTRL, {12'h000, 4'hF, UNLOCK[15:0]});
		cpu_u.set_be(4'hF);
		fst = 1'b1;
		repeat (2) @(negedge clk_i);
		`CHK({fatal, brk, srst}, 3'b111)
		fst = 1'b0;
		// reset in mid-run clears the status
		nrst_i = 1'b0;
		repeat (2) @(negedge clk_i);
		nrst_i = 1'b1;
		@(negedge clk_i);
		`CHK({fatal, brk, srst, recov, k2ok}, 5'b00000)
		br(OFF_FFS, got);
		`CHK(got, 32'h0000_0000)
		results();
	end
endmodule : tb_top
